// File: inc/srm_pkg.sv
// Purpose: Shared constants and types for the system reset, mode and clock-out controller.
// Assumes: Registers are reached over a plain strobe port with 16-bit data in the low bits.
// Notes: Offsets are indices on the register port.
package srm_pkg;
   // ==========================================================================
   // Register map
   localparam logic [3:0] addr_mode_word = 4'h0;
   localparam logic [3:0] addr_clock_out = 4'h1;
   localparam logic [3:0] addr_sys_ctrl = 4'h2;
   localparam logic [3:0] addr_status = 4'h3;
   localparam logic [3:0] addr_sw_reset = 4'h4;
   localparam logic [3:0] addr_gp_base = 4'h8;
   localparam int gp_count = 4;
   // ==========================================================================
   // Field positions
   localparam int mode_boot_low_bit = 0;
   localparam int mode_boot_high_bit = 1;
   localparam int clk_pin7_bit = 9;
   localparam int clk_pin6_bit = 8;
   localparam int clk_pin5_bit = 7;
   localparam int clk_pin4_bit = 6;
   localparam int clk_off_bit = 5;
   localparam int ctl_wait_en_bit = 0;
   localparam int ctl_stop_en_bit = 1;
   localparam int ctl_wait_wd_stop_bit = 2;
   localparam int ctl_wait_pwm_off_bit = 3;
   localparam int ctl_dbg_pwm_off_bit = 4;
   localparam int ctl_stop_wd_stop_bit = 5;
   localparam int ctl_stop_can_stop_bit = 6;
   localparam logic [15:0] clock_out_mask = 16'h03ff;
   localparam logic [15:0] sys_ctrl_mask = 16'h007f;
   localparam logic [15:0] sw_reset_key = 16'h0001;
   // ==========================================================================
   // Reset values
   localparam logic [15:0] mode_word_reset = 16'h0000;
   localparam logic [15:0] clock_out_reset = 16'h0000;
   localparam logic [15:0] sys_ctrl_reset = 16'h0003;
   localparam logic [1:0] boot_secured = 2'h0;
   localparam logic [1:0] boot_open = 2'h0;
   // ==========================================================================
   // Clock-out source codes
   localparam logic [4:0] src_sys_clock = 5'h00;
   localparam logic [4:0] src_osc = 5'h07;
   localparam logic [4:0] src_synth = 5'h08;
   // ==========================================================================
   // Reset extension timing
   localparam int ext_phase_clocks = 32;
   localparam int ext_phase_count = 3;
   localparam int por_ext_clocks = 2097152;
   typedef enum logic [2:0] {st_run, st_wait, st_stop, st_debug} srm_mode_type;
   typedef enum logic [2:0] {ph_hold, ph_one, ph_two, ph_three, ph_done} srm_phase_type;
endpackage

// File: inc/srm_gp_if.sv
`timescale 1ns/10ps
// Purpose: Carries access signals from the controller to its general-purpose store.
// Assumes: One access per cycle.
// Notes: None.
interface srm_gp_if;
   logic wr;
   logic [1:0] idx;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport ctrl (output wr, output idx, output wdata, input rdata);
   modport store (input wr, input idx, input wdata, output rdata);
endinterface

// File: core/srm_gp_store.sv
`timescale 1ns/10ps
// Purpose: Four 16-bit general-purpose words cleared only by power-on reset.
// Assumes: Read data come out of a register one cycle after the index.
// Notes: Only the power-on reset input clears the words.
module srm_gp_store (
   // Clock and power-on reset
   input wire logic core_clk,
   input wire logic por_reset,
   // Access port
   srm_gp_if.store gp
);
   logic [15:0] mem_q [srm_pkg::gp_count];
   logic [15:0] rdata_q;

   genvar i;
   generate
      for (i = 0; i < srm_pkg::gp_count; i++) begin : g_word
         always_ff @(posedge core_clk) begin
            if (por_reset) begin
               mem_q[i] <= 16'h0000;
            end else if (gp.wr && gp.idx == 2'(i)) begin
               mem_q[i] <= gp.wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      rdata_q <= mem_q[gp.idx];
   end

   assign gp.rdata = rdata_q;
endmodule

// File: core/srm_ctrl.sv
`timescale 1ns/10ps
// Purpose: Reset extension, operating mode control and clock-out steering for the system glue unit.
// Assumes: All inputs synchronous to core_clk; the oscillator-derived clock is core_clk.
// Notes: Long power-on count is a parameter so simulation can shorten it.
//
// How it works
// - Hold resets three phases of 32 clocks, released in stages; 2^21 after power-on.
// - Power-on or reset pin resets core and all peripherals.
// - Watchdog or software reset resets everything but keeps the boot-mode bits and the general words.
// - Debug mode: watchdog off, PWM optionally off, other peripherals run.
// - Wait mode: core and memory clocks off, watchdog and PWM optionally off.
// - Stop mode: core, memory, most peripheral clocks off; watchdog, CAN optional.
// - Wake from stop on CAN activity or any non-gated interrupt.
// - Software enables let wait and stop instructions take effect or not.
// - Four 16-bit general words cleared only by power-on reset.
// - Clock-out control bits 15 to 10 read zero and ignore writes.
// - Bit 9 picks address bit 23 or master oscillator on port B line 7.
// - Bit 8 picks address bit 22 or secondary system clock on port B line 6.
// - Bit 7 picks address bit 21 or system clock on port B line 5.
// - Bit 6 picks address bit 20 or prescaler reference on port B line 4.
// - Bit 5 clear drives selected clock on clock-out pin; set tri-states it.
// - Mode word bits 15 to 2 reset to zero; boot bits reset to 00 whether flash is secured or not.
// - Source select: 00000 system clock, 00111 oscillator, 01000 synthesizer.
module srm_ctrl #(
   parameter int por_ext_clocks = srm_pkg::por_ext_clocks
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Reset sources
   input wire logic por_in,
   input wire logic reset_pin_n,
   input wire logic watchdog_reset,
   input wire logic flash_secured,
   // Core requests
   input wire logic wait_instr,
   input wire logic stop_instr,
   input wire logic debug_req,
   input wire logic can_activity,
   input wire logic irq_pending,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Clock sources and address bits
   input wire logic system_clock_signal,
   input wire logic system_clock_twin,
   input wire logic master_osc_clock,
   input wire logic prescaler_ref_clock,
   input wire logic osc_out_clock,
   input wire logic synth_out_clock,
   input wire logic [3:0] addr_high,
   // Resets out
   output logic core_reset,
   output logic periph_reset,
   output logic mem_reset,
   // Clock gates and mode effects
   output logic core_clk_en,
   output logic mem_clk_en,
   output logic periph_clk_en,
   output logic watchdog_en,
   output logic pwm_off,
   output logic can_clk_en,
   // Pins
   output logic [3:0] port_b_alt_out,
   output logic clock_out_signal,
   output logic clock_out_pin_oe_n
);
   localparam int por_w = $clog2(por_ext_clocks + 1);
   localparam logic [por_w-1:0] por_load = por_w'(por_ext_clocks - 1);
   localparam logic [por_w-1:0] phase_load = por_w'(srm_pkg::ext_phase_clocks - 1);

   // ==========================================================================
   // Reset source detection
   logic hard_src;
   logic soft_src;
   logic sw_reset_req;
   logic any_src;
   assign hard_src = por_in | ~reset_pin_n;
   assign soft_src = watchdog_reset | sw_reset_req;
   assign any_src = hard_src | soft_src | reset;
   assign sw_reset_req = reg_wr && reg_addr == srm_pkg::addr_sw_reset && reg_wdata == srm_pkg::sw_reset_key;

   // ==========================================================================
   // Reset extension
   srm_pkg::srm_phase_type phase_q;
   logic [por_w-1:0] ext_cnt_q;
   logic por_seen_q;
   logic hard_seen_q;

   always_ff @(posedge core_clk) begin
      if (any_src) begin
         phase_q <= srm_pkg::ph_hold;
         ext_cnt_q <= (por_in || reset) ? por_load : phase_load;
      end else begin
         case (phase_q)
            srm_pkg::ph_hold: begin
               if (ext_cnt_q == '0) begin
                  phase_q <= srm_pkg::ph_one;
                  ext_cnt_q <= phase_load;
               end else begin
                  ext_cnt_q <= ext_cnt_q - 1'b1;
               end
            end
            srm_pkg::ph_one, srm_pkg::ph_two: begin
               if (ext_cnt_q == '0) begin
                  phase_q <= (phase_q == srm_pkg::ph_one) ? srm_pkg::ph_two : srm_pkg::ph_three;
                  ext_cnt_q <= phase_load;
               end else begin
                  ext_cnt_q <= ext_cnt_q - 1'b1;
               end
            end
            srm_pkg::ph_three: begin
               phase_q <= srm_pkg::ph_done;
            end
            srm_pkg::ph_done: begin
               phase_q <= srm_pkg::ph_done;
            end
            default: begin
               phase_q <= srm_pkg::ph_hold;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || por_in) begin
         por_seen_q <= 1'b1;
      end else if (phase_q == srm_pkg::ph_done) begin
         por_seen_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (hard_src || reset) begin
         hard_seen_q <= 1'b1;
      end else if (phase_q == srm_pkg::ph_done) begin
         hard_seen_q <= 1'b0;
      end
   end

   // Staged release: peripherals, then memory, then core.
   always_ff @(posedge core_clk) begin
      if (any_src) begin
         periph_reset <= 1'b1;
         mem_reset <= 1'b1;
         core_reset <= 1'b1;
      end else begin
         periph_reset <= phase_q == srm_pkg::ph_hold;
         mem_reset <= phase_q == srm_pkg::ph_hold || phase_q == srm_pkg::ph_one;
         core_reset <= phase_q != srm_pkg::ph_done && phase_q != srm_pkg::ph_three;
      end
   end

   // ==========================================================================
   // Registers
   logic [15:0] mode_word_q;
   logic [15:0] clock_out_q;
   logic [15:0] sys_ctrl_q;
   logic wr_mode;
   assign wr_mode = reg_wr && reg_addr == srm_pkg::addr_mode_word;

   always_ff @(posedge core_clk) begin
      if (hard_src || reset) begin
         mode_word_q <= srm_pkg::mode_word_reset;
         mode_word_q[srm_pkg::mode_boot_high_bit:srm_pkg::mode_boot_low_bit] <=
            flash_secured ? srm_pkg::boot_secured : srm_pkg::boot_open;
      end else if (soft_src) begin
         mode_word_q[15:2] <= 14'h0000;
      end else if (wr_mode) begin
         mode_word_q <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (hard_src || soft_src || reset) begin
         clock_out_q <= srm_pkg::clock_out_reset;
         sys_ctrl_q <= srm_pkg::sys_ctrl_reset;
      end else if (reg_wr && reg_addr == srm_pkg::addr_clock_out) begin
         clock_out_q <= reg_wdata & srm_pkg::clock_out_mask;
      end else if (reg_wr && reg_addr == srm_pkg::addr_sys_ctrl) begin
         sys_ctrl_q <= reg_wdata & srm_pkg::sys_ctrl_mask;
      end
   end

   // ==========================================================================
   // General-purpose store
   srm_gp_if gp_bus ();
   logic gp_hit;
   logic gp_rd_q;
   assign gp_hit = reg_addr[3:2] == srm_pkg::addr_gp_base[3:2];
   assign gp_bus.wr = reg_wr && gp_hit;
   assign gp_bus.idx = reg_addr[1:0];
   assign gp_bus.wdata = reg_wdata;

   srm_gp_store u_gp (
      .core_clk(core_clk),
      .por_reset(por_in | reset),
      .gp(gp_bus.store)
   );

   // ==========================================================================
   // Operating mode
   srm_pkg::srm_mode_type mode_q;

   always_ff @(posedge core_clk) begin
      if (any_src) begin
         mode_q <= srm_pkg::st_run;
      end else begin
         case (mode_q)
            srm_pkg::st_run: begin
               if (debug_req) begin
                  mode_q <= srm_pkg::st_debug;
               end else if (stop_instr && sys_ctrl_q[srm_pkg::ctl_stop_en_bit]) begin
                  mode_q <= srm_pkg::st_stop;
               end else if (wait_instr && sys_ctrl_q[srm_pkg::ctl_wait_en_bit]) begin
                  mode_q <= srm_pkg::st_wait;
               end
            end
            srm_pkg::st_wait: begin
               if (irq_pending || debug_req) begin
                  mode_q <= srm_pkg::st_run;
               end
            end
            srm_pkg::st_stop: begin
               if (irq_pending || can_activity) begin
                  mode_q <= srm_pkg::st_run;
               end
            end
            srm_pkg::st_debug: begin
               if (!debug_req) begin
                  mode_q <= srm_pkg::st_run;
               end
            end
            default: begin
               mode_q <= srm_pkg::st_run;
            end
         endcase
      end
   end

   // Stop leaves the PLL alone; software shuts it down before entry.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         core_clk_en <= 1'b1;
         mem_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         watchdog_en <= 1'b1;
         pwm_off <= 1'b0;
         can_clk_en <= 1'b1;
      end else begin
         core_clk_en <= mode_q == srm_pkg::st_run || mode_q == srm_pkg::st_debug;
         mem_clk_en <= mode_q == srm_pkg::st_run || mode_q == srm_pkg::st_debug;
         periph_clk_en <= mode_q != srm_pkg::st_stop;
         watchdog_en <= !(mode_q == srm_pkg::st_debug
                          || (mode_q == srm_pkg::st_wait && sys_ctrl_q[srm_pkg::ctl_wait_wd_stop_bit])
                          || (mode_q == srm_pkg::st_stop && sys_ctrl_q[srm_pkg::ctl_stop_wd_stop_bit]));
         pwm_off <= (mode_q == srm_pkg::st_debug && sys_ctrl_q[srm_pkg::ctl_dbg_pwm_off_bit])
                    || (mode_q == srm_pkg::st_wait && sys_ctrl_q[srm_pkg::ctl_wait_pwm_off_bit]);
         can_clk_en <= !(mode_q == srm_pkg::st_stop && sys_ctrl_q[srm_pkg::ctl_stop_can_stop_bit]);
      end
   end

   // ==========================================================================
   // Clock-out and port B steering
   logic clk_sel;
   always_comb begin
      case (clock_out_q[4:0])
         srm_pkg::src_sys_clock: clk_sel = system_clock_signal;
         srm_pkg::src_osc: clk_sel = osc_out_clock;
         srm_pkg::src_synth: clk_sel = synth_out_clock;
         default: clk_sel = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         port_b_alt_out <= 4'h0;
         clock_out_signal <= 1'b0;
         clock_out_pin_oe_n <= 1'b1;
      end else begin
         port_b_alt_out[3] <= clock_out_q[srm_pkg::clk_pin7_bit] ? master_osc_clock : addr_high[3];
         port_b_alt_out[2] <= clock_out_q[srm_pkg::clk_pin6_bit] ? system_clock_twin : addr_high[2];
         port_b_alt_out[1] <= clock_out_q[srm_pkg::clk_pin5_bit] ? system_clock_signal : addr_high[1];
         port_b_alt_out[0] <= clock_out_q[srm_pkg::clk_pin4_bit] ? prescaler_ref_clock : addr_high[0];
         clock_out_signal <= clk_sel;
         clock_out_pin_oe_n <= clock_out_q[srm_pkg::clk_off_bit];
      end
   end

   // ==========================================================================
   // Read port
   logic [3:0] rd_addr_q;
   logic rd_q;
   always_ff @(posedge core_clk) begin
      rd_q <= reg_rd;
      rd_addr_q <= reg_addr;
      gp_rd_q <= reg_rd && gp_hit;
   end

   always_comb begin
      case (rd_addr_q)
         srm_pkg::addr_mode_word: reg_rdata = mode_word_q;
         srm_pkg::addr_clock_out: reg_rdata = clock_out_q;
         srm_pkg::addr_sys_ctrl: reg_rdata = sys_ctrl_q;
         srm_pkg::addr_status: reg_rdata = {11'h000, hard_seen_q, por_seen_q, 1'b0, mode_q[1:0]};
         default: reg_rdata = gp_rd_q ? gp_bus.rdata : 16'h0000;
      endcase
      if (!rd_q) begin
         reg_rdata = 16'h0000;
      end
   end
endmodule

// File: tb/srm_ctrl_monitor.sv
// Purpose: Concurrent checks on the ports of the reset, mode and clock-out controller.
// Assumes: One clock domain; bound to every srm_ctrl instance.
// Notes: Staged release is checked as two 32-clock gaps.
`timescale 1ns/10ps
module srm_ctrl_monitor #(
   parameter int por_ext_clocks = 64
) (
   // Clock, reset and sources
   input wire logic core_clk,
   input wire logic reset,
   input wire logic reset_pin_n,
   input wire logic watchdog_reset,
   input wire logic debug_req,
   input wire logic irq_pending,
   input wire logic can_activity,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Resets and gates
   input wire logic core_reset,
   input wire logic periph_reset,
   input wire logic mem_reset,
   input wire logic core_clk_en,
   input wire logic mem_clk_en,
   input wire logic periph_clk_en,
   input wire logic watchdog_en
);
   // ==========================================================================
   // Checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   chk_mem_stage_gap: assert property ($fell(periph_reset) |-> ##32 $fell(mem_reset))
      else $error("memory reset not released 32 clocks after peripherals");
   chk_core_stage_gap: assert property ($fell(mem_reset) |-> ##32 $fell(core_reset))
      else $error("core reset not released 32 clocks after memories");
   chk_pin_resets_all: assert property (!reset_pin_n |=> core_reset && periph_reset && mem_reset)
      else $error("reset pin did not reset everything");
   chk_wdog_resets_all: assert property (watchdog_reset |=> core_reset && periph_reset && mem_reset)
      else $error("watchdog reset did not reset everything");
   chk_debug_wdog_off: assert property ((debug_req && !core_reset) [*4] |-> !watchdog_en)
      else $error("watchdog still enabled in debug mode");
   chk_core_mem_gate: assert property (!core_clk_en |-> !mem_clk_en)
      else $error("memory clock running with core clock stopped");
   chk_stop_gate_all: assert property (!periph_clk_en |-> !core_clk_en)
      else $error("core clock running with peripheral clocks stopped");
   chk_irq_wake_core: assert property (!core_clk_en && irq_pending |-> ##[1:4] core_clk_en)
      else $error("interrupt did not restart the core clock");
   chk_can_wake_stop: assert property (!periph_clk_en && can_activity |-> ##[1:4] periph_clk_en)
      else $error("bus activity did not wake from stop");
   chk_clock_out_signal_top_zero: assert property (reg_rd && reg_addr == srm_pkg::addr_clock_out |=> reg_rdata[15:10] == 6'h00)
      else $error("clock-out control upper bits not zero");
endmodule
bind srm_ctrl srm_ctrl_monitor #(.por_ext_clocks(por_ext_clocks)) u_monitor (.*);

// File: tb/srm_far_side.sv
// Purpose: Clock sources and address lines seen by the controller.
// Assumes: Sources change only after the rising edge.
// Notes: Each source is a counter bit, an inverted counter bit or a mix of bits so every mux leg differs.
`timescale 1ns/10ps
module srm_far_side (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Sources
   output logic system_clock_signal,
   output logic system_clock_twin,
   output logic master_osc_clock,
   output logic prescaler_ref_clock,
   output logic osc_out_clock,
   output logic synth_out_clock,
   output logic [3:0] addr_high
);
   logic [7:0] cnt_q;
   // Sources keep running; any shutdown before stop is left to software.
   always_ff @(posedge core_clk) begin
      cnt_q <= reset ? 8'h00 : cnt_q + 8'h01;
   end
   assign system_clock_signal = cnt_q[0];
   assign system_clock_twin = cnt_q[1];
   assign master_osc_clock = cnt_q[2];
   assign prescaler_ref_clock = cnt_q[3];
   assign osc_out_clock = ~cnt_q[0];
   assign synth_out_clock = cnt_q[1] ^ cnt_q[2];
   assign addr_high = cnt_q[7:4] ^ cnt_q[3:0];
endmodule

// File: tb/srm_ctrl_bench.sv
// Purpose: Self-checking bench for the reset, mode and clock-out controller.
// Assumes: Power-on extension shortened to 64 clocks.
// Notes: Reads are checked against a queue of expected words.
`timescale 1ns/10ps
module srm_ctrl_bench;
   localparam int por_clocks = 64;
   logic core_clk, reset, por_in, reset_pin_n, watchdog_reset, flash_secured;
   logic wait_instr, stop_instr, debug_req, can_activity, irq_pending, reg_wr, reg_rd;
   logic [3:0] reg_addr, addr_high, port_b_alt_out, pa, pc;
   logic [15:0] reg_wdata, reg_rdata, cfg, v;
   logic system_clock_signal, system_clock_twin, master_osc_clock;
   logic prescaler_ref_clock, osc_out_clock, synth_out_clock;
   logic core_reset, periph_reset, mem_reset, core_clk_en, mem_clk_en, periph_clk_en;
   logic watchdog_en, pwm_off, can_clk_en, clock_out_signal, clock_out_pin_oe_n;
   logic [15:0] exp_q[$];
   logic [15:0] g[4];
   logic [4:0] srcs[4];
   logic [2:0] po;
   logic rd_prev, mux_on;
   int errors, checked, cycles, seed, n;
   // ==========================================================================
   // Design, far side and clock
   srm_ctrl #(.por_ext_clocks(por_clocks)) i_dut (.*);
   srm_far_side i_far (.*);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ==========================================================================
   // Tasks
   task final_report;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task cmp16(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cmp1(input logic got, input logic exp);
      cmp16({15'h0000, got}, {15'h0000, exp});
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask
   task strobe(input int k);
      @(posedge core_clk);
      case (k)
         0: wait_instr <= 1'b1;
         1: stop_instr <= 1'b1;
         2: irq_pending <= 1'b1;
         3: can_activity <= 1'b1;
         default: watchdog_reset <= 1'b1;
      endcase
      @(posedge core_clk);
      {wait_instr, stop_instr, irq_pending, can_activity, watchdog_reset} <= 5'h00;
      repeat (4) @(posedge core_clk);
   endtask
   task wait_rel;
      n = 0;
      repeat (3) @(posedge core_clk);
      while (core_reset !== 1'b0 && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      cmp1(core_reset, 1'b0);
   endtask
   // ==========================================================================
   // Result watcher
   always @(posedge core_clk) begin
      if (rd_prev) cmp16(reg_rdata, exp_q.pop_front());
      if (mux_on) begin
         cmp16({12'h000, port_b_alt_out}, {12'h000, (cfg[9:6] & pc) | (~cfg[9:6] & pa)});
         cmp1(clock_out_pin_oe_n, cfg[5]);
         if (!cfg[5]) cmp1(clock_out_signal, cfg[4:0] == 5'h00 ? po[2] : cfg[4:0] == 5'h07 ? po[1] :
            cfg[4:0] == 5'h08 ? po[0] : 1'b0);
      end
      rd_prev <= reg_rd;
      pa <= addr_high;
      pc <= {master_osc_clock, system_clock_twin, system_clock_signal, prescaler_ref_clock};
      po <= {system_clock_signal, osc_out_clock, synth_out_clock};
      cycles++;
      if (cycles == 30000) begin
         errors++;
         final_report;
      end
   end
   // ==========================================================================
   // Scenarios
   initial begin
      {por_in, flash_secured, watchdog_reset, wait_instr, stop_instr} = 5'h00;
      {debug_req, can_activity, irq_pending, reg_wr, reg_rd, rd_prev, mux_on} = 7'h00;
      {reg_addr, reg_wdata, cfg} = 36'h0_0000_0000;
      reset = 1'b1;
      reset_pin_n = 1'b1;
      {errors, checked, cycles} = 0;
      seed = 32'h7113;
      srcs = '{5'h00, 5'h07, 5'h08, 5'h03};
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      #1 n = 0;
      while (periph_reset !== 1'b0 && n < 400) begin
         @(posedge core_clk);
         #1 n++;
      end
      cmp16(16'(n), 16'(por_clocks + 1));
      wait_rel;
      rd(srm_pkg::addr_mode_word, srm_pkg::mode_word_reset);
      rd(srm_pkg::addr_clock_out, srm_pkg::clock_out_reset);
      rd(srm_pkg::addr_sys_ctrl, srm_pkg::sys_ctrl_reset);
      rd(4'h5, 16'h0000);
      wr(srm_pkg::addr_clock_out, 16'hffff);
      rd(srm_pkg::addr_clock_out, 16'h03ff);
      for (int i = 0; i < 8; i++) begin
         v = 16'($random(seed));
         v[4:0] = srcs[i % 4];
         wr(srm_pkg::addr_clock_out, v);
         cfg <= v & srm_pkg::clock_out_mask;
         repeat (3) @(posedge core_clk);
         mux_on <= 1'b1;
         repeat (10) @(posedge core_clk);
         mux_on <= 1'b0;
      end
      wr(srm_pkg::addr_sys_ctrl, 16'h0000);
      strobe(0);
      cmp1(core_clk_en, 1'b1);
      strobe(1);
      cmp1(periph_clk_en, 1'b1);
      wr(srm_pkg::addr_sys_ctrl, 16'h000d);
      strobe(0);
      cmp16(16'({core_clk_en, mem_clk_en, periph_clk_en, watchdog_en, pwm_off}), 16'h0005);
      rd(srm_pkg::addr_status, 16'h0001);
      strobe(2);
      cmp16(16'({core_clk_en, watchdog_en, pwm_off}), 16'h0006);
      wr(srm_pkg::addr_sys_ctrl, 16'h0062);
      strobe(1);
      cmp16(16'({core_clk_en, mem_clk_en, periph_clk_en, watchdog_en, can_clk_en}), 16'h0000);
      strobe(3);
      cmp16(16'({periph_clk_en, can_clk_en}), 16'h0003);
      wr(srm_pkg::addr_sys_ctrl, 16'h0010);
      @(posedge core_clk);
      debug_req <= 1'b1;
      repeat (6) @(posedge core_clk);
      cmp16(16'({core_clk_en, watchdog_en, pwm_off}), 16'h0005);
      debug_req <= 1'b0;
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < 4; i++) begin
            g[i] = 16'($random(seed));
            wr(srm_pkg::addr_gp_base + 4'(i), g[i]);
         end
         wr(srm_pkg::addr_mode_word, 16'h0081);
         if (s == 0) strobe(4);
         else wr(srm_pkg::addr_sw_reset, srm_pkg::sw_reset_key);
         wait_rel;
         for (int i = 0; i < 4; i++) rd(srm_pkg::addr_gp_base + 4'(i), g[i]);
         rd(srm_pkg::addr_mode_word, 16'h0001);
         rd(srm_pkg::addr_clock_out, 16'h0000);
      end
      @(posedge core_clk);
      reset_pin_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      reset_pin_n <= 1'b1;
      #1 cmp16(16'({core_reset, periph_reset, mem_reset}), 16'h0007);
      wait_rel;
      rd(srm_pkg::addr_mode_word, srm_pkg::mode_word_reset);
      rd(srm_pkg::addr_gp_base, g[0]);
      @(posedge core_clk);
      por_in <= 1'b1;
      @(posedge core_clk);
      por_in <= 1'b0;
      wait_rel;
      rd(srm_pkg::addr_gp_base + 4'h1, 16'h0000);
      rd(srm_pkg::addr_mode_word, srm_pkg::mode_word_reset);
      wr(srm_pkg::addr_gp_base, g[1]);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      wait_rel;
      for (int i = 0; i < 4; i++) rd(srm_pkg::addr_gp_base + 4'(i), 16'h0000);
      repeat (3) @(posedge core_clk);
      final_report;
   end
endmodule
